// ===== csc_pkg.sv
package csc_pkg;

	// ----------------------------------------------------------------
	// register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_CLKSEL  = 8'h00;
	localparam logic [7:0] ADDR_PRESC   = 8'h04;
	localparam logic [7:0] ADDR_PLL     = 8'h08;
	localparam logic [7:0] ADDR_OSCCTRL = 8'h0c;
	localparam logic [7:0] ADDR_SLEEP   = 8'h10;
	localparam logic [7:0] ADDR_PWRRED  = 8'h14;
	localparam logic [7:0] ADDR_STATUS  = 8'h18;
	localparam logic [7:0] ADDR_WAKEEN  = 8'h1c;

	// ----------------------------------------------------------------
	// clock source codes
	// ----------------------------------------------------------------
	localparam logic [2:0] SRC_RC2M  = 3'h0;
	localparam logic [2:0] SRC_RC32M = 3'h1;
	localparam logic [2:0] SRC_RC32K = 3'h2;
	localparam logic [2:0] SRC_XOSC  = 3'h3;
	localparam logic [2:0] SRC_PLL   = 3'h4;
	localparam logic [2:0] SRC_XT32K = 3'h5;
	localparam logic [2:0] SRC_EXT   = 3'h6;
	localparam int         NUM_SRC   = 7;

	// ----------------------------------------------------------------
	// sleep mode codes
	// ----------------------------------------------------------------
	localparam logic [2:0] SLP_IDLE  = 3'h0;
	localparam logic [2:0] SLP_PDOWN = 3'h2;
	localparam logic [2:0] SLP_PSAVE = 3'h3;
	localparam logic [2:0] SLP_STDBY = 3'h6;
	localparam logic [2:0] SLP_ESTBY = 3'h7;

	// ----------------------------------------------------------------
	// field positions and limits
	// ----------------------------------------------------------------
	localparam int          OSC_FMON_BIT  = 0;
	localparam int          OSC_CAL_BIT   = 1;
	localparam int          OSC_CALREF    = 2;
	localparam int          OSC_RTCSRC    = 3;
	localparam int          SLP_EN_BIT    = 3;
	localparam logic [4:0]  PLL_MIN       = 5'h01;
	localparam logic [11:0] PRESC_MAX     = 12'h800;
	localparam logic [11:0] PRESC_RESET   = 12'h001;
	localparam logic [4:0]  PLL_RESET     = 5'h01;
	localparam int          PERIPH_N      = 16;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_MHZ          = 200;
	localparam int FAIL_TIME_US     = 2;
	localparam int FAIL_CYC         = FAIL_TIME_US * CLK_MHZ;
	localparam int SWITCH_SETTLE    = 4;
	localparam int RTC_SRC_LP       = 0;

endpackage

// ===== csc_top.sv
// What this block does
// - reset always selects 2 MHz internal oscillator
// - source switch is glitch-free, gated handover
// - crystal failure raises NMI, falls back
// - PLL factor settable from 1 to 31
// - prescaler ratio settable in powers of two from 1 to 2048
// - fast peripheral clocks at two, four times
// - low-power oscillator never system, not controllable
// - calibrated 32k oscillator: system or RTC source
// - watch crystal: system or RTC source
// - run-time calibration trims 2M and 32M
// - five sleep modes, entered only from Active
// - permitted interrupt or reset wakes device
// - power reduction bit stops peripheral clock
// - idle stops CPU and memory only
// - power-down halts all sources and RTC
// - power-down wakes on TWI match, pin
// - power-save keeps enabled RTC and its wake
// - standby keeps sources, gates CPU, peripherals, RTC
// - extended standby keeps sources and RTC
//
// Our own choices: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module csc_top
	import csc_pkg::*;
#(
	parameter int FAIL_CYCLES = FAIL_CYC,
	parameter int NPER        = PERIPH_N
) (
	input  wire logic             hclk,
	input  wire logic             hresetn,
	input  wire logic             hsel,
	input  wire logic [31:0]      haddr,
	input  wire logic [1:0]       htrans,
	input  wire logic             hwrite,
	input  wire logic [2:0]       hsize,
	input  wire logic [31:0]      hwdata,
	input  wire logic             hready,
	output logic      [31:0]      hrdata,
	output logic                  hreadyout,
	output logic                  hresp,
	input  wire logic [NUM_SRC-1:0] src_tick,
	input  wire logic             low_power_osc_tick,
	input  wire logic             sleep_req,
	input  wire logic             irq_any,
	input  wire logic             irq_twi_match,
	input  wire logic             irq_pin_async,
	input  wire logic             irq_rtc,
	input  wire logic             cal_ref_rc32k,
	input  wire logic             cal_ref_xt32k,
	output logic                  cpu_clk_en,
	output logic                  nvm_clk_en,
	output logic                  per_clk_en,
	output logic                  per2x_clk_en,
	output logic                  per4x_clk_en,
	output logic      [NPER-1:0]  per_gate_en,
	output logic                  rtc_clk_en,
	output logic                  rtc_src_xtal,
	output logic                  wdt_tick,
	output logic      [NUM_SRC-1:0] osc_run,
	output logic      [4:0]       pll_mult,
	output logic                  nmi,
	output logic                  cal_step,
	output logic                  cal_up,
	output logic                  sleeping
);

	// ----------------------------------------------------------------
	// control registers
	// ----------------------------------------------------------------
	logic [2:0]      clk_sel;       // requested source
	logic [2:0]      clk_act;       // source actually driving
	logic [11:0]     presc;
	logic [4:0]      pll_fac;
	logic [3:0]      osc_ctrl;
	logic [3:0]      sleep_ctrl;
	logic [NPER-1:0] pwr_red;
	logic            xosc_fail;

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	logic       ap_write;
	logic [7:0] ap_addr;
	wire        take      = hsel & hready & htrans[1];
	wire        wr_clksel = ap_write & (ap_addr == ADDR_CLKSEL);
	wire        wr_presc  = ap_write & (ap_addr == ADDR_PRESC);
	wire        wr_pll    = ap_write & (ap_addr == ADDR_PLL);
	wire        wr_osc    = ap_write & (ap_addr == ADDR_OSCCTRL);
	wire        wr_sleep  = ap_write & (ap_addr == ADDR_SLEEP);
	wire        wr_pwrred = ap_write & (ap_addr == ADDR_PWRRED);
	wire        wr_status = ap_write & (ap_addr == ADDR_STATUS);
	wire [11:0] presc_in  = hwdata[11:0];
	wire [4:0]  pll_in    = hwdata[4:0];
	wire        presc_ok  = (presc_in != 12'h000) && (presc_in <= PRESC_MAX)
		&& ((presc_in & (presc_in - 12'h001)) == 12'h000);
	wire        pll_ok    = pll_in >= PLL_MIN;
	wire        src_ok    = hwdata[2:0] < 3'(NUM_SRC);

	// address phase capture, one-cycle data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ap_write <= 1'b0;
			ap_addr  <= 8'h00;
		end else begin
			ap_write <= take & hwrite;
			ap_addr  <= take ? haddr[7:0] : ap_addr;
		end
	end

	// ----------------------------------------------------------------
	// sleep state machine
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {ST_ACTIVE, ST_SLEEP, ST_WAKE} csc_state_e;
	csc_state_e state;
	csc_state_e next_state;
	logic [2:0] wake_cnt;
	wire  [2:0] smode     = sleep_ctrl[2:0];
	wire        is_idle   = smode == SLP_IDLE;
	wire        rtc_mode  = (smode == SLP_PSAVE) | (smode == SLP_ESTBY);
	wire        keep_src  = (smode == SLP_STDBY) | (smode == SLP_ESTBY);
	wire        mode_ok   = is_idle | rtc_mode | keep_src | (smode == SLP_PDOWN);
	wire        wake_deep = irq_twi_match | irq_pin_async | (rtc_mode & irq_rtc);
	wire        wake      = is_idle ? irq_any : wake_deep;
	wire        in_sleep  = state == ST_SLEEP;

	// next sleep state
	always_comb begin
		next_state = state;
		case (state)
			ST_ACTIVE: begin
				if (sleep_req & sleep_ctrl[SLP_EN_BIT] & mode_ok) begin
					next_state = ST_SLEEP;
				end
			end
			ST_SLEEP: begin
				if (wake) begin
					next_state = ST_WAKE;
				end
			end
			ST_WAKE: begin
				if (wake_cnt == 3'(SWITCH_SETTLE - 1)) begin
					next_state = ST_ACTIVE;
				end
			end
			default: next_state = ST_ACTIVE;
		endcase
	end

	// state register and wake settle count
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state    <= ST_ACTIVE;
			wake_cnt <= 3'h0;
		end else begin
			state    <= next_state;
			wake_cnt <= (state == ST_WAKE) ? wake_cnt + 3'h1 : 3'h0;
		end
	end

	// ----------------------------------------------------------------
	// software-written registers
	// ----------------------------------------------------------------
	// failure detect, ahead of the source register that it overrides
	logic [15:0] fail_cnt;
	wire  xosc_used = (clk_act == SRC_XOSC) | (clk_act == SRC_PLL) | (clk_act == SRC_EXT);
	wire  fmon_on   = osc_ctrl[OSC_FMON_BIT] & xosc_used & ~in_sleep;
	wire  fail_now  = fmon_on & (fail_cnt == 16'(FAIL_CYCLES - 1)) & ~src_tick[clk_act];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			clk_sel    <= SRC_RC2M;
			presc      <= PRESC_RESET;
			pll_fac    <= PLL_RESET;
			osc_ctrl   <= 4'h0;
			sleep_ctrl <= 4'h0;
			pwr_red    <= '0;
		end else begin
			if (wr_clksel & src_ok) clk_sel <= hwdata[2:0];
			if (wr_presc & presc_ok) presc <= presc_in;
			if (wr_pll & pll_ok) pll_fac <= pll_in;
			if (wr_osc) osc_ctrl <= hwdata[3:0];
			if (wr_sleep) sleep_ctrl <= hwdata[3:0];
			if (wr_pwrred) pwr_red <= hwdata[NPER-1:0];
			if (fail_now) clk_sel <= SRC_RC2M;
		end
	end

	// ----------------------------------------------------------------
	// crystal failure monitor
	// ----------------------------------------------------------------
	// silence counter; failure flag set wins over software clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fail_cnt  <= 16'h0000;
			xosc_fail <= 1'b0;
			nmi       <= 1'b0;
		end else begin
			fail_cnt  <= (!fmon_on || src_tick[clk_act] || fail_now) ? 16'h0000
				: fail_cnt + 16'h0001;
			xosc_fail <= fail_now | (xosc_fail & ~(wr_status & hwdata[0]));
			nmi       <= fail_now;
		end
	end

	// ----------------------------------------------------------------
	// glitch-free switch: old source gated off, then new one on
	// ----------------------------------------------------------------
	logic [2:0] sw_cnt;
	wire  sw_pend = clk_sel != clk_act;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			clk_act <= SRC_RC2M;
			sw_cnt  <= 3'h0;
		end else if (sw_pend && sw_cnt == 3'(SWITCH_SETTLE - 1)) begin
			clk_act <= clk_sel;
			sw_cnt  <= 3'h0;
		end else begin
			sw_cnt  <= sw_pend ? sw_cnt + 3'h1 : 3'h0;
		end
	end

	// ----------------------------------------------------------------
	// prescaler chain: base tick is four times the CPU rate
	// ----------------------------------------------------------------
	logic [11:0] div_cnt;
	logic [1:0]  ph;
	wire  src_edge  = src_tick[clk_act] & ~sw_pend;
	wire  div_last  = div_cnt >= presc - 12'h001;
	wire  base_tick = src_edge & div_last;
	wire  run_cpu   = state == ST_ACTIVE;
	wire  run_per   = run_cpu | (in_sleep & is_idle) | (state == ST_WAKE);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div_cnt <= 12'h000;
			ph      <= 2'h0;
		end else if (src_edge) begin
			div_cnt <= div_last ? 12'h000 : div_cnt + 12'h001;
			ph      <= div_last ? ph + 2'h1 : ph;
		end
	end

	// ----------------------------------------------------------------
	// gated clock enables, all registered
	// ----------------------------------------------------------------
	logic [NPER-1:0] next_gate;

	genvar g;
	generate
		for (g = 0; g < NPER; g++) begin : g_per
			assign next_gate[g] = base_tick & (ph == 2'h3) & run_per & ~pwr_red[g];
		end
	endgenerate

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cpu_clk_en   <= 1'b0;
			nvm_clk_en   <= 1'b0;
			per_clk_en   <= 1'b0;
			per2x_clk_en <= 1'b0;
			per4x_clk_en <= 1'b0;
			per_gate_en  <= '0;
		end else begin
			cpu_clk_en   <= base_tick & (ph == 2'h3) & run_cpu;
			nvm_clk_en   <= base_tick & (ph == 2'h3) & run_cpu;
			per_clk_en   <= base_tick & (ph == 2'h3) & run_per;
			per2x_clk_en <= base_tick & ph[0] & run_per;
			per4x_clk_en <= base_tick & run_per;
			per_gate_en  <= next_gate;
		end
	end

	// ----------------------------------------------------------------
	// oscillators, RTC and low-power tick
	// ----------------------------------------------------------------
	logic [NUM_SRC-1:0] next_osc;
	wire  src_halt = in_sleep & ~is_idle & ~keep_src;
	wire  rtc_run  = ~in_sleep | is_idle | rtc_mode;

	generate
		for (g = 0; g < NUM_SRC; g++) begin : g_osc
			assign next_osc[g] = ~src_halt & ((3'(g) == clk_act) | (3'(g) == clk_sel)
				| ((g == int'(SRC_XOSC)) & (clk_act == SRC_PLL)));
		end
	endgenerate

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			osc_run      <= '0;
			rtc_clk_en   <= 1'b0;
			rtc_src_xtal <= 1'b0;
			wdt_tick     <= 1'b0;
			pll_mult     <= PLL_RESET;
			sleeping     <= 1'b0;
		end else begin
			osc_run      <= next_osc;
			rtc_clk_en   <= rtc_run & src_tick[osc_ctrl[OSC_RTCSRC] ? SRC_XT32K : SRC_RC32K];
			rtc_src_xtal <= osc_ctrl[OSC_RTCSRC];
			wdt_tick     <= low_power_osc_tick;
			pll_mult     <= pll_fac;
			sleeping     <= in_sleep;
		end
	end

	// ----------------------------------------------------------------
	// run-time calibration: count fast ticks per reference tick
	// ----------------------------------------------------------------
	logic [15:0] cal_cnt;
	localparam logic [15:0] CAL_TARGET = 16'd61;
	wire  cal_ref  = osc_ctrl[OSC_CALREF] ? cal_ref_xt32k : cal_ref_rc32k;
	wire  cal_on   = osc_ctrl[OSC_CAL_BIT] & ~in_sleep;
	wire  cal_osc  = clk_act == SRC_RC32M ? src_tick[SRC_RC32M] : src_tick[SRC_RC2M];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cal_cnt  <= 16'h0000;
			cal_step <= 1'b0;
			cal_up   <= 1'b0;
		end else begin
			cal_step <= cal_on & cal_ref;
			cal_up   <= (cal_on & cal_ref) ? (cal_cnt < CAL_TARGET) : cal_up;
			cal_cnt  <= (cal_ref | ~cal_on) ? 16'h0000 : cal_cnt + {15'h0000, cal_osc};
		end
	end

	// ----------------------------------------------------------------
	// read mux
	// ----------------------------------------------------------------
	wire        rd_sel = take & ~hwrite;
	wire [31:0] rd_val =
		(haddr[7:0] == ADDR_CLKSEL)  ? {26'h0, clk_act, clk_sel} :
		(haddr[7:0] == ADDR_PRESC)   ? {20'h0, presc} :
		(haddr[7:0] == ADDR_PLL)     ? {27'h0, pll_fac} :
		(haddr[7:0] == ADDR_OSCCTRL) ? {28'h0, osc_ctrl} :
		(haddr[7:0] == ADDR_SLEEP)   ? {28'h0, sleep_ctrl} :
		(haddr[7:0] == ADDR_PWRRED)  ? 32'(pwr_red) :
		(haddr[7:0] == ADDR_STATUS)  ? {28'h0, state == ST_ACTIVE, sw_pend, in_sleep, xosc_fail} :
		32'h0000_0000;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata    <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hrdata    <= rd_sel ? rd_val : hrdata;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

endmodule
`default_nettype wire

// ===== csc_properties.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// clock and sleep control checks
// ----------------------------------------------------------------
module csc_properties
	import csc_pkg::*;
#(
	parameter int NPER = PERIPH_N
) (
	input wire logic            hclk,
	input wire logic            hresetn,
	input wire logic            hreadyout,
	input wire logic            hresp,
	input wire logic            low_power_osc_tick,
	input wire logic            wdt_tick,
	input wire logic [4:0]      pll_mult,
	input wire logic            cpu_clk_en,
	input wire logic            nvm_clk_en,
	input wire logic            per_clk_en,
	input wire logic            per2x_clk_en,
	input wire logic            per4x_clk_en,
	input wire logic [NPER-1:0] per_gate_en,
	input wire logic            nmi,
	input wire logic            sleeping
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// register bus never stalls nor errors
	bus_ready_a: assert property (hreadyout) else $error("bus slave stalled");
	bus_okay_a: assert property (!hresp) else $error("bus error response");
	// watchdog tick follows the low-power oscillator by one cycle
	wdt_follow_a: assert property (low_power_osc_tick |=> wdt_tick) else $error("wdt tick lost");
	wdt_source_a: assert property (wdt_tick |-> $past(low_power_osc_tick))
		else $error("wdt tick without cause");
	// multiplier never leaves its range floor
	pll_floor_a: assert property (pll_mult != 5'h00) else $error("pll factor zero");
	// fast clocks nest inside each other and the 2x clock never runs back to back
	fast_nest_a: assert property (per2x_clk_en |-> per4x_clk_en) else $error("2x without 4x");
	cpu_nest_a: assert property (cpu_clk_en |-> per2x_clk_en) else $error("cpu without 2x");
	half_rate_a: assert property (per2x_clk_en |=> !per2x_clk_en) else $error("2x too fast");
	// core and memory stay stopped while asleep
	sleep_gate_a: assert property (sleeping && $past(sleeping) |-> !cpu_clk_en && !nvm_clk_en)
		else $error("core clock while asleep");
	nmi_pulse_a: assert property (nmi |=> !nmi) else $error("nmi longer than one cycle");
	gate_mask_a: assert property (|per_gate_en |-> per_clk_en) else $error("gate without base");

	cover property (nmi);
	cover property ($rose(sleeping));
	cover property (|per_gate_en);
endmodule
`default_nettype wire

// ===== csc_partner.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// oscillator and reference sources
// ----------------------------------------------------------------
module csc_partner
	import csc_pkg::*;
(
	input wire logic             hclk,
	input wire logic             hresetn,
	input wire logic             xosc_stop,
	output logic [NUM_SRC-1:0]   src_tick,
	output logic                 low_power_osc_tick,
	output logic                 cal_ref_rc32k,
	output logic                 cal_ref_xt32k
);
	logic [9:0] cnt;

	// free-running phase counter
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			cnt <= '0;
		else
			cnt <= cnt + 10'h001;
	end

	// each source ticks at its own rate; a stopped crystal gives no edges
	always_comb begin
		for (int i = 0; i < NUM_SRC; i++)
			src_tick[i] = (cnt % (i + 2)) == 0 && !(i == int'(SRC_XOSC) && xosc_stop);
	end
	assign low_power_osc_tick = cnt[5:0] == 6'h00;
	assign cal_ref_rc32k      = cnt[6:0] == 7'h05;
	assign cal_ref_xt32k      = cnt[6:0] == 7'h09;
endmodule
`default_nettype wire

// ===== clock_and_sleep_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// clock and sleep control bench
// ----------------------------------------------------------------
module clock_and_sleep_control_bench
	import csc_pkg::*;
;
	localparam int         FAILN = 40;
	localparam logic [2:0] MD [5] = '{SLP_IDLE, SLP_PDOWN, SLP_PSAVE, SLP_STDBY, SLP_ESTBY};
	localparam int         WK [5] = '{0, 2, 3, 1, 3};
	localparam int         NW [5] = '{0, 3, 0, 3, 0};
	logic               hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
	logic [31:0]        haddr, hwdata, hrdata, q;
	logic [1:0]         htrans;
	logic [2:0]         hsize;
	logic [3:0]         irqs;
	logic               sleep_req, xosc_stop, wdt_tick, nmi, cal_step, cal_up, sleeping;
	logic               cpu_clk_en, nvm_clk_en, per_clk_en, per2x_clk_en, per4x_clk_en;
	logic               rtc_clk_en, rtc_src_xtal, low_power_osc_tick, cal_ref_rc32k, cal_ref_xt32k;
	logic [NUM_SRC-1:0] src_tick, osc_run;
	logic [15:0]        per_gate_en;
	logic [4:0]         pll_mult;
	int                 bad_count, checks_done, n, m;

	assign hready = hreadyout;

	csc_top #(.FAIL_CYCLES(FAILN)) i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hwdata, .hready, .hrdata, .hreadyout, .hresp, .src_tick, .low_power_osc_tick, .sleep_req,
		.irq_any(irqs[0]), .irq_twi_match(irqs[1]), .irq_pin_async(irqs[2]), .irq_rtc(irqs[3]),
		.cal_ref_rc32k, .cal_ref_xt32k, .cpu_clk_en, .nvm_clk_en, .per_clk_en, .per2x_clk_en,
		.per4x_clk_en, .per_gate_en, .rtc_clk_en, .rtc_src_xtal, .wdt_tick, .osc_run, .pll_mult,
		.nmi, .cal_step, .cal_up, .sleeping);
	csc_partner i_far (.hclk, .hresetn, .xosc_stop, .src_tick, .low_power_osc_tick,
		.cal_ref_rc32k, .cal_ref_xt32k);

	// 200 MHz clock
	initial begin
		hclk = 1'b0;
		forever #2.5 hclk = ~hclk;
	end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			$display("Error at %0t: got %h want %h", $time, got, exp);
			bad_count++;
		end
	endtask

	// one single-word transfer, address phase then data phase
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'b10;
		hwrite <= w;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= d;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		q = hrdata;
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask

	task rd(input logic [7:0] a, input logic [31:0] msk, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(q & msk, e);
	endtask

	task automatic wait_on(ref logic s, input logic v);
		for (int i = 0; i < 300 && s !== v; i++) @(posedge hclk);
	endtask

	task go_sleep(input logic [2:0] md);
		wr(ADDR_SLEEP, {28'h0, 1'b1, md});
		sleep_req <= 1'b1;
		@(posedge hclk);
		sleep_req <= 1'b0;
		wait_on(sleeping, 1'b1);
	endtask

	task t_regs;
		rd(ADDR_CLKSEL, 32'h3f, 32'h0);
		rd(ADDR_PRESC, 32'hffff_ffff, 32'h1);
		rd(ADDR_PLL, 32'hffff_ffff, 32'h1);
		wr(8'h20, 32'hffff_ffff);
		rd(8'h20, 32'hffff_ffff, 32'h0);
		wr(ADDR_PRESC, 32'h800);
		rd(ADDR_PRESC, 32'hfff, 32'h800);
		wr(ADDR_PRESC, 32'h3);
		rd(ADDR_PRESC, 32'hfff, 32'h800);
		wr(ADDR_PRESC, 32'h1);
		wr(ADDR_PLL, 32'h1f);
		repeat (2) @(posedge hclk);
		chk(32'(pll_mult), 32'h1f);
		wr(ADDR_PLL, 32'h0);
		rd(ADDR_PLL, 32'h1f, 32'h1f);
	endtask

	task t_switch;
		for (int i = 0; i < NUM_SRC; i++) begin
			wr(ADDR_CLKSEL, 32'(i));
			repeat (20) @(posedge hclk);
			rd(ADDR_CLKSEL, 32'h3f, {26'h0, i[2:0], i[2:0]});
		end
		wr(ADDR_CLKSEL, 32'h7);
		repeat (20) @(posedge hclk);
		rd(ADDR_CLKSEL, 32'h38, 32'h30);
		wr(ADDR_CLKSEL, 32'h0);
		repeat (20) @(posedge hclk);
	endtask

	task t_fail;
		wr(ADDR_OSCCTRL, 32'h1);
		wr(ADDR_CLKSEL, {29'h0, SRC_XOSC});
		repeat (20) @(posedge hclk);
		xosc_stop <= 1'b1;
		wait_on(nmi, 1'b1);
		chk(32'(nmi), 32'h1);
		xosc_stop <= 1'b0;
		repeat (10) @(posedge hclk);
		rd(ADDR_CLKSEL, 32'h38, 32'h0);
		rd(ADDR_STATUS, 32'h1, 32'h1);
		wr(ADDR_STATUS, 32'h1);
		rd(ADDR_STATUS, 32'h1, 32'h0);
		for (int r = 0; r < 2; r++) begin
			wr(ADDR_OSCCTRL, {28'h0, r[0], r[0], 2'b10});
			m = 0;
			repeat (1500) begin
				@(posedge hclk);
				if (cal_step === 1'b1) m++;
			end
			chk(32'(m != 0), 32'h1);
			// 64 slow-source ticks per reference period exceed the target: trim down
			chk(32'(cal_up), 32'h0);
			chk(32'(rtc_src_xtal), 32'(r[0]));
		end
		wr(ADDR_OSCCTRL, 32'h0);
		@(posedge hclk);
		m = 0;
		repeat (300) begin
			@(posedge hclk);
			if (cal_step === 1'b1) m++;
		end
		chk(32'(m), 32'h0);
	endtask

	task t_sleep;
		for (int k = 0; k < 5; k++) begin
			go_sleep(MD[k]);
			chk(32'(sleeping), 32'h1);
			if (k > 0) begin
				irqs[NW[k]] <= 1'b1;
			end
			n = 0;
			m = 0;
			repeat (30) begin
				@(posedge hclk);
				if (rtc_clk_en === 1'b1) n++;
				if (per_clk_en === 1'b1) m++;
			end
			chk(32'(sleeping), 32'h1);
			chk(32'(osc_run != '0), 32'(k == 0 || k > 2));
			chk(32'(n != 0), 32'(k != 1 && k != 3));
			chk(32'(m != 0), 32'(k == 0));
			irqs <= 4'(1 << WK[k]);
			wait_on(sleeping, 1'b0);
			chk(32'(sleeping), 32'h0);
			irqs <= 4'h0;
			wait_on(cpu_clk_en, 1'b1);
			chk(32'(cpu_clk_en), 32'h1);
		end
		wr(ADDR_SLEEP, 32'h0);
	endtask

	task t_gate;
		wr(ADDR_PWRRED, 32'h1);
		n = 0;
		m = 0;
		repeat (200) begin
			@(posedge hclk);
			if (per_gate_en[0] === 1'b1) n++;
			if (per_gate_en[1] === 1'b1) m++;
		end
		chk(32'(n), 32'h0);
		chk(32'(m != 0), 32'h1);
		wr(ADDR_PWRRED, 32'h0);
		wait_on(cpu_clk_en, 1'b1);
		n = 0;
		m = 0;
		do begin
			@(posedge hclk);
			if (per4x_clk_en === 1'b1) n++;
			if (per2x_clk_en === 1'b1) m++;
		end while (cpu_clk_en !== 1'b1);
		chk(32'(n), 32'h4);
		chk(32'(m), 32'h2);
	endtask

	task t_rst;
		wr(ADDR_CLKSEL, 32'h1);
		repeat (20) @(posedge hclk);
		go_sleep(SLP_PDOWN);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		chk(32'(sleeping), 32'h0);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd(ADDR_CLKSEL, 32'h3f, 32'h0);
	endtask

	task print_verdict;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// main sequence
	initial begin
		{hresetn, hsel, hwrite, sleep_req, xosc_stop} = '0;
		{haddr, hwdata, htrans, irqs} = '0;
		hsize = 3'b010;
		bad_count = 0;
		checks_done = 0;
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_regs;
		t_switch;
		t_fail;
		t_sleep;
		t_gate;
		t_rst;
		print_verdict;
	end

	// watchdog against a hang
	initial begin
		repeat (30000) @(posedge hclk);
		bad_count++;
		print_verdict;
	end
endmodule

bind csc_top csc_properties #(.NPER(NPER)) i_prop (.hclk, .hresetn, .hreadyout, .hresp,
	.low_power_osc_tick, .wdt_tick, .pll_mult, .cpu_clk_en, .nvm_clk_en, .per_clk_en,
	.per2x_clk_en, .per4x_clk_en, .per_gate_en, .nmi, .sleeping);
`default_nettype wire
